/* logic/eub_pkg.sv */
// constants shared by the enhanced serial port
`default_nettype none
package eub_pkg;
    // ==========================================================
    // frame and mode encodings
    localparam int DATA_W = 8;
    localparam int DIV_W = 16;
    localparam logic [1:0] MODE_SHIFT = 2'h0;
    localparam logic [1:0] MODE_UART8 = 2'h1;
    localparam logic [1:0] MODE_FIX9 = 2'h2;
    localparam logic [1:0] MODE_VAR9 = 2'h3;
    localparam logic [3:0] BITS_SHIFT = 4'h8;
    localparam logic [3:0] BITS_UART8 = 4'ha;
    localparam logic [3:0] BITS_UART9 = 4'hb;
    // ==========================================================
    // bit timing: sixteen ticks to a bit
    localparam int OSR = 16;
    localparam logic [3:0] PH_LAST = 4'(OSR - 1);
    localparam logic [3:0] PH_MID = 4'(OSR / 2 - 1);
    localparam logic [3:0] PH_SCLK_RISE = 4'(OSR / 2 - 1);
    localparam int BREAK_BITS = 11;
    localparam logic [7:0] BREAK_TICKS = 8'(BREAK_BITS * OSR);
    // ==========================================================
    // reset values
    localparam logic TXD_IDLE = 1'b1;
    localparam logic [DIV_W-1:0] BRG_RST = 16'h0000;
    localparam logic [8:0] WORD_RST = 9'h000;
    typedef enum logic {EUB_RX_IDLE, EUB_RX_RUN} eub_rx_st_t;
endpackage : eub_pkg
`default_nettype wire

/* logic/eub_uart.sv */
// enhanced serial port: shift-register and asynchronous modes with baud selection
`default_nettype none
// How it works
// - shift mode: data on rxd, clock txd, 8 bits lsb first
// - shift mode bit rate is clock over 16
// - 8-bit mode: start, 8 data, stop
// - 8-bit mode stores stop bit as ninth
// - 8-bit mode rate from timer or generator
// - 9-bit modes: start, 8 data, ninth, stop
// - 9-bit receive keeps ninth, drops stop
// - fixed 9-bit rate clock over 16 or 32
// - variable 9-bit mode uses timer or generator
// - generator divides clock by 16-bit divisor plus one
// - timer overflow halved when doubling off
// - framing error flagged; bit7 view selectable
// - break after 11 low bit periods
// - break may request a device reset
// - double buffer: next character after one stop
// - double buffer off: single buffered
// - timer overflow usable even when timer stopped
// - double buffer: done when buffer frees
module eub_uart (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic mode_select_high,
    input wire logic mode_select_low,
    input wire logic baud_double_select,
    input wire logic frame_err_view_select,
    input wire logic tx_double_buffer_en,
    input wire logic baud_src_gen,
    input wire logic [eub_pkg::DATA_W-1:0] baud_divisor_high,
    input wire logic [eub_pkg::DATA_W-1:0] baud_divisor_low,
    input wire logic timer1_ovf,
    input wire logic rx_enable,
    input wire logic break_reset_en,
    input wire logic frame_err_clr,
    input wire logic break_clr,
    input wire logic [eub_pkg::DATA_W-1:0] tx_data,
    input wire logic tx_ninth_bit,
    input wire logic tx_valid,
    output logic tx_ready,
    output logic [eub_pkg::DATA_W-1:0] rx_data,
    output logic rx_ninth_bit,
    output logic rx_valid,
    input wire logic rx_ready,
    input wire logic rxd_in,
    output logic rxd_out,
    output logic rxd_oe,
    output logic txd_out,
    output logic tx_done,
    output logic rx_done,
    output logic frame_err,
    output logic break_det,
    output logic ctl_bit7,
    output logic break_reset_req
);
    import eub_pkg::*;

    // ==========================================================
    // mode decode
    logic [1:0] mode;
    logic m_shift;
    logic [3:0] nbits;
    assign mode = {mode_select_high, mode_select_low};
    assign m_shift = (mode == MODE_SHIFT);
    // frame length per mode
    assign nbits = m_shift ? BITS_SHIFT :
                   (mode == MODE_UART8) ? BITS_UART8 :
                   BITS_UART9;

    // ==========================================================
    // receive pin synchroniser
    logic rx_s1_q;
    logic rx_s_q;
    logic rx_p_q;
    // two stages before use, third only for edge detection
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rx_s1_q <= 1'b1;
            rx_s_q <= 1'b1;
            rx_p_q <= 1'b1;
        end else begin
            rx_s1_q <= rxd_in;
            rx_s_q <= rx_s1_q;
            rx_p_q <= rx_s_q;
        end
    end

    // ==========================================================
    // baud tick generation (sixteen ticks per bit)
    logic [DIV_W-1:0] brg_q;
    logic brg_tick;
    logic t1h_q;
    logic ch_q;
    logic tick;
    // divisor period is value plus one clocks
    assign brg_tick = (brg_q == {baud_divisor_high, baud_divisor_low});

    // free-running counter keeps timer one free for other work
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            brg_q <= BRG_RST;
        end else if (brg_tick) begin
            brg_q <= BRG_RST;
        end else begin
            brg_q <= brg_q + 16'h0001;
        end
    end

    // halving toggles for timer overflow and clock
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            t1h_q <= 1'b0;
            ch_q <= 1'b0;
        end else begin
            if (timer1_ovf) begin
                t1h_q <= ~t1h_q;
            end
            ch_q <= ~ch_q;
        end
    end

    // tick source select; overflow is taken even if the timer is stopped
    always_comb begin
        tick = 1'b0;
        case (mode)
            MODE_SHIFT: begin
                tick = 1'b1;
            end
            MODE_FIX9: begin
                tick = baud_double_select | ch_q;
            end
            default: begin
                tick = baud_src_gen ? brg_tick
                     : (timer1_ovf & (baud_double_select | t1h_q));
            end
        endcase
    end

    // ==========================================================
    // transmit holding register
    logic hold_v_q;
    logic [8:0] hold_q;
    logic tx_ready_q;
    logic acc;
    logic load;
    logic fin;
    logic bit_end;
    logic busy_q;
    logic m0rx_q;
    logic m0_start;
    logic tv_q;
    assign acc = tx_valid & tx_ready_q;
    // back-to-back load at the last stop tick gives exactly one stop bit
    assign load = hold_v_q & (~busy_q | fin);

    // ninth bit is captured with the byte
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            hold_v_q <= 1'b0;
            hold_q <= WORD_RST;
        end else if (acc) begin
            hold_v_q <= 1'b1;
            hold_q <= {tx_ninth_bit, tx_data};
        end else if (load) begin
            hold_v_q <= 1'b0;
        end
    end

    // ready is one cycle conservative so no write is ever overrun
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            tx_ready_q <= 1'b0;
        end else begin
            tx_ready_q <= ~acc & ~hold_v_q & (tx_double_buffer_en | ~busy_q);
        end
    end

    // ==========================================================
    // shift engine: async transmit and both shift-mode directions
    logic [3:0] ph_q;
    logic [3:0] bit_q;
    logic [10:0] sh_q;
    logic [7:0] m0d_q;
    logic txd_q;
    logic rxo_q;
    logic rxoe_q;
    logic tx_done_q;
    assign bit_end = busy_q & tick & (ph_q == PH_LAST);
    assign fin = bit_end & (bit_q == nbits - 4'h1);
    // shift-mode receive waits for an idle engine and buffer room
    assign m0_start = m_shift & rx_enable & ~busy_q & ~hold_v_q & ~tv_q;

    // one engine serves both shift-mode directions (half duplex)
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            busy_q <= 1'b0;
            m0rx_q <= 1'b0;
            ph_q <= 4'h0;
            bit_q <= 4'h0;
            sh_q <= 11'h7ff;
            m0d_q <= 8'h00;
            txd_q <= TXD_IDLE;
            rxo_q <= 1'b1;
            rxoe_q <= 1'b0;
        end else if (load) begin
            busy_q <= 1'b1;
            m0rx_q <= 1'b0;
            ph_q <= 4'h0;
            bit_q <= 4'h0;
            txd_q <= 1'b0; // start bit, or shift clock low
            if (m_shift) begin
                sh_q <= {3'h7, hold_q[7:0]};
                rxo_q <= hold_q[0];
                rxoe_q <= 1'b1;
            end else begin
                // eight-bit mode sends stop in the ninth slot
                sh_q <= {1'b1, (mode == MODE_UART8) | hold_q[8],
                         hold_q[7:0], 1'b0};
                rxoe_q <= 1'b0;
            end
        end else if (m0_start) begin
            busy_q <= 1'b1;
            m0rx_q <= 1'b1;
            ph_q <= 4'h0;
            bit_q <= 4'h0;
            txd_q <= 1'b0;
            rxoe_q <= 1'b0;
        end else if (busy_q & tick) begin
            ph_q <= ph_q + 4'h1;
            if (m_shift & (ph_q == PH_SCLK_RISE)) begin
                txd_q <= 1'b1;
                if (m0rx_q) begin
                    m0d_q <= {rx_s_q, m0d_q[7:1]};
                end
            end
            if (bit_end) begin
                bit_q <= bit_q + 4'h1;
                sh_q <= {1'b1, sh_q[10:1]};
                if (m_shift) begin
                    txd_q <= 1'b0;
                    rxo_q <= sh_q[1];
                end else begin
                    txd_q <= sh_q[1];
                end
                if (fin) begin
                    busy_q <= 1'b0;
                    txd_q <= TXD_IDLE;
                    rxo_q <= 1'b1;
                    rxoe_q <= 1'b0;
                end
            end
        end
    end

    // completion pulse: buffer free when doubled, frame end otherwise
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            tx_done_q <= 1'b0;
        end else if (tx_double_buffer_en) begin
            tx_done_q <= load;
        end else begin
            tx_done_q <= fin & ~m0rx_q;
        end
    end

    // ==========================================================
    // asynchronous receiver
    eub_rx_st_t rst_q;
    logic [3:0] rph_q;
    logic [3:0] rbit_q;
    logic [7:0] rd_q;
    logic r9_q;
    logic rx_last;
    logic rx_ninth;
    logic m0_push;
    // last sample of the frame is the stop bit
    assign rx_last = (rst_q == EUB_RX_RUN) & tick & (rph_q == PH_MID)
                   & (rbit_q == nbits - 4'h1);
    assign rx_ninth = (mode == MODE_UART8) ? rx_s_q : r9_q;
    assign m0_push = fin & m0rx_q;

    // start needs room in the buffer so a finished word is never dropped
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rst_q <= EUB_RX_IDLE;
            rph_q <= 4'h0;
            rbit_q <= 4'h0;
            rd_q <= 8'h00;
            r9_q <= 1'b0;
        end else begin
            case (rst_q)
                EUB_RX_IDLE: begin
                    if (~m_shift & rx_enable & ~tv_q & rx_p_q & ~rx_s_q) begin
                        rst_q <= EUB_RX_RUN;
                        rph_q <= 4'h0;
                        rbit_q <= 4'h0;
                    end
                end
                EUB_RX_RUN: begin
                    if (tick) begin
                        rph_q <= rph_q + 4'h1;
                        if (rph_q == PH_MID) begin
                            rbit_q <= rbit_q + 4'h1;
                            if ((rbit_q == 4'h0) & rx_s_q) begin
                                rst_q <= EUB_RX_IDLE; // glitch, not a start
                            end else if ((rbit_q != 4'h0) & (rbit_q < 4'h9)) begin
                                rd_q <= {rx_s_q, rd_q[7:1]};
                            end else if (rbit_q == 4'h9) begin
                                r9_q <= rx_s_q;
                            end
                            if (rbit_q == nbits - 4'h1) begin
                                rst_q <= EUB_RX_IDLE;
                            end
                        end
                    end
                end
                default: begin
                    rst_q <= EUB_RX_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // two-entry receive buffer
    logic hv_q;
    logic [8:0] head_q;
    logic [8:0] tail_q;
    logic push;
    logic pop;
    logic [8:0] pw;
    assign push = rx_last | m0_push;
    assign pop = hv_q & rx_ready;
    assign pw = rx_last ? {rx_ninth, rd_q} : {1'b0, m0d_q};

    // head is the output word, tail the overflow slot
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            hv_q <= 1'b0;
            tv_q <= 1'b0;
            head_q <= WORD_RST;
            tail_q <= WORD_RST;
        end else if (pop) begin
            if (tv_q) begin
                head_q <= tail_q;
                tv_q <= push;
                if (push) begin
                    tail_q <= pw;
                end
            end else if (push) begin
                head_q <= pw;
            end else begin
                hv_q <= 1'b0;
            end
        end else if (push) begin
            if (!hv_q) begin
                head_q <= pw;
                hv_q <= 1'b1;
            end else begin
                tail_q <= pw;
                tv_q <= 1'b1;
            end
        end
    end

    // ==========================================================
    // framing error, break and status flags
    logic [7:0] lc_q;
    logic brk_set;
    logic fe_q;
    logic brk_q;
    logic brst_q;
    logic ctl7_q;
    logic rx_done_q;
    assign brk_set = tick & ~m_shift & ~rx_s_q & (lc_q == BREAK_TICKS - 8'h01);

    // counts ticks of continuous low line, independent of framing
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            lc_q <= 8'h00;
        end else if (m_shift | rx_s_q) begin
            lc_q <= 8'h00;
        end else if (tick & (lc_q != BREAK_TICKS)) begin
            lc_q <= lc_q + 8'h01;
        end
    end

    // sticky flags: a set in the clear cycle wins
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            fe_q <= 1'b0;
            brk_q <= 1'b0;
            brst_q <= 1'b0;
            ctl7_q <= 1'b0;
            rx_done_q <= 1'b0;
        end else begin
            if (rx_last & ~rx_s_q) begin
                fe_q <= 1'b1;
            end else if (frame_err_clr) begin
                fe_q <= 1'b0;
            end
            if (brk_set) begin
                brk_q <= 1'b1;
            end else if (break_clr) begin
                brk_q <= 1'b0;
            end
            brst_q <= brk_set & break_reset_en;
            // mode bit is only visible while the view select is clear
            ctl7_q <= frame_err_view_select ? fe_q : mode_select_high;
            rx_done_q <= push;
        end
    end

    // ==========================================================
    // outputs, all straight from flops
    assign tx_ready = tx_ready_q;
    assign rx_data = head_q[7:0];
    assign rx_ninth_bit = head_q[8];
    assign rx_valid = hv_q;
    assign rxd_out = rxo_q;
    assign rxd_oe = rxoe_q;
    assign txd_out = txd_q;
    assign tx_done = tx_done_q;
    assign rx_done = rx_done_q;
    assign frame_err = fe_q;
    assign break_det = brk_q;
    assign ctl_bit7 = ctl7_q;
    assign break_reset_req = brst_q;
endmodule : eub_uart
`default_nettype wire

/* testbench/eub_uart_checker.sv */
// concurrent checks on the serial port top-level ports
`default_nettype none
module eub_uart_checker (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic mode_select_high,
    input wire logic mode_select_low,
    input wire logic frame_err_view_select,
    input wire logic tx_double_buffer_en,
    input wire logic break_reset_en,
    input wire logic frame_err_clr,
    input wire logic break_clr,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic [eub_pkg::DATA_W-1:0] rx_data,
    input wire logic rx_ninth_bit,
    input wire logic rx_valid,
    input wire logic rx_ready,
    input wire logic rxd_oe,
    input wire logic txd_out,
    input wire logic tx_done,
    input wire logic rx_done,
    input wire logic frame_err,
    input wire logic break_det,
    input wire logic ctl_bit7,
    input wire logic break_reset_req
);
    timeunit 1ns;
    timeprecision 1ps;
    import eub_pkg::*;
    // ==========================================================
    // one clock domain, so clocking and reset are stated once
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);
    // single-buffered write in an async mode, then the start bit
    sequence s_async_take;
        tx_valid && tx_ready && !tx_double_buffer_en && (mode_select_high || mode_select_low);
    endsequence
    sequence s_start_low;
        ##[1:8] !txd_out;
    endsequence
    a_tx_start_low: assert property (s_async_take |-> s_start_low)
        else $error("start bit missing after write");
    a_take_ready_drop: assert property (tx_valid && tx_ready |=> !tx_ready)
        else $error("ready stayed up after a write");
    a_oe_shift_only: assert property (rxd_oe |-> !mode_select_high && !mode_select_low)
        else $error("data pin driven outside shift mode");
    a_rx_word_hold: assert property (rx_valid && !rx_ready |=>
        rx_valid && $stable(rx_data) && $stable(rx_ninth_bit))
        else $error("received word changed while stalled");
    a_ferr_sticky: assert property (frame_err && !frame_err_clr |=> frame_err)
        else $error("framing flag lost without clear");
    a_brk_sticky: assert property (break_det && !break_clr |=> break_det)
        else $error("break flag lost without clear");
    a_ctl_view: assert property (1'h1 |=> ctl_bit7 == ($past(frame_err_view_select) ?
        $past(frame_err) : $past(mode_select_high)))
        else $error("control bit 7 shows the wrong source");
    a_brk_req_pulse: assert property (break_reset_req |->
        break_reset_en ##1 !break_reset_req)
        else $error("break reset request wrong");
    a_tx_done_pulse: assert property (tx_done |=> !tx_done)
        else $error("transmit done longer than a cycle");
    a_rx_done_pulse: assert property (rx_done |=> !rx_done)
        else $error("receive done longer than a cycle");
    a_db_done_start: assert property (tx_double_buffer_en && tx_done |-> !txd_out)
        else $error("done not at start bit");
endmodule : eub_uart_checker
bind eub_uart eub_uart_checker i_eub_uart_checker (.clk_sys(clk_sys), .arst_n(arst_n),
    .mode_select_high(mode_select_high), .mode_select_low(mode_select_low),
    .frame_err_view_select(frame_err_view_select), .tx_double_buffer_en(tx_double_buffer_en),
    .break_reset_en(break_reset_en), .frame_err_clr(frame_err_clr), .break_clr(break_clr),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_ninth_bit(rx_ninth_bit),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rxd_oe(rxd_oe), .txd_out(txd_out),
    .tx_done(tx_done), .rx_done(rx_done), .frame_err(frame_err), .break_det(break_det),
    .ctl_bit7(ctl_bit7), .break_reset_req(break_reset_req));
`default_nettype wire

/* testbench/eub_remote.sv */
// remote serial partner: drives the receive line, captures transmit frames
`default_nettype none
module eub_remote (
    input wire logic clk_sys,
    input wire logic txd_out,
    output logic rxd_line
);
    timeunit 1ns;
    timeprecision 1ps;
    int cyc_q = 0;
    // ==========================================================
    // cycle count to time frame starts
    always @(posedge clk_sys) begin
        cyc_q <= cyc_q + 1;
    end
    // line idles at mark level
    initial begin
        rxd_line = 1'h1;
    end
    // n bits lsb first, bc clocks each, then back to mark
    task automatic send(input logic [10:0] f, input int n, input int bc);
        for (int i = 0; i < n; i++) begin
            rxd_line = f[i];
            repeat (bc) @(posedge clk_sys);
            #1;
        end
        rxd_line = 1'h1;
    endtask : send
    // wait for a start edge, sample mid-bit; returns at mid of last bit
    task automatic grab(output logic [10:0] f, output int t0, input int n, input int bc);
        f = 11'h000;
        while (txd_out !== 1'h0) begin
            @(posedge clk_sys);
            #1;
        end
        t0 = cyc_q;
        repeat (bc / 2) @(posedge clk_sys);
        #1;
        for (int i = 0; i < n; i++) begin
            if (i > 0) begin
                repeat (bc) @(posedge clk_sys);
                #1;
            end
            f[i] = txd_out;
        end
    endtask : grab
endmodule : eub_remote
`default_nettype wire

/* testbench/tb_top.sv */
// self-checking bench for the enhanced serial port
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import eub_pkg::*;
    logic clk_sys = 1'h0, arst_n = 1'h0, mode_select_high = 1'h0, mode_select_low = 1'h0;
    logic baud_double_select = 1'h1, frame_err_view_select = 1'h0, tx_double_buffer_en = 1'h0;
    logic baud_src_gen = 1'h1, timer1_ovf = 1'h0, rx_enable = 1'h0, break_reset_en = 1'h0;
    logic frame_err_clr = 1'h0, break_clr = 1'h0, tx_ninth_bit = 1'h0, tx_valid = 1'h0;
    logic rx_ready = 1'h0, req_seen = 1'h0;
    logic [7:0] baud_divisor_high = 8'h00, baud_divisor_low = 8'h00, tx_data = 8'h00, rx_data;
    logic tx_ready, rx_ninth_bit, rx_valid, rxd_out, rxd_oe, txd_out, tx_done, rx_done;
    logic frame_err, break_det, ctl_bit7, break_reset_req, rxd_line, rxd_pin;
    int bad_count = 0, cmp_count = 0, cyc = 0;
    // pin level: the port drives it while sending in shift mode, else the partner
    assign rxd_pin = rxd_oe ? rxd_out : rxd_line;
    eub_uart i_eub_uart (.clk_sys(clk_sys), .arst_n(arst_n), .mode_select_high(mode_select_high),
        .mode_select_low(mode_select_low), .baud_double_select(baud_double_select),
        .frame_err_view_select(frame_err_view_select), .tx_double_buffer_en(tx_double_buffer_en),
        .baud_src_gen(baud_src_gen), .baud_divisor_high(baud_divisor_high),
        .baud_divisor_low(baud_divisor_low), .timer1_ovf(timer1_ovf), .rx_enable(rx_enable),
        .break_reset_en(break_reset_en), .frame_err_clr(frame_err_clr), .break_clr(break_clr),
        .tx_data(tx_data), .tx_ninth_bit(tx_ninth_bit), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .rx_data(rx_data), .rx_ninth_bit(rx_ninth_bit), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .rxd_in(rxd_pin), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd_out(txd_out),
        .tx_done(tx_done), .rx_done(rx_done), .frame_err(frame_err), .break_det(break_det),
        .ctl_bit7(ctl_bit7), .break_reset_req(break_reset_req));
    eub_remote i_eub_remote (.clk_sys(clk_sys), .txd_out(txd_out), .rxd_line(rxd_line));
    // ==========================================================
    // clock, timer overflow every second clock, pulse catcher, hang limit
    initial begin
        forever #2 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        #1;
        timer1_ovf = ~timer1_ovf;
    end
    always @(posedge clk_sys) begin
        cyc++;
        if (break_reset_req === 1'h1) req_seen <= 1'h1;
        if (cyc == 20000) begin
            bad_count++;
            results();
        end
    end
    // ==========================================================
    // shared tasks
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic results();
        $display("compares=%0d mismatches=%0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : results
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : step
    task automatic cfg(input logic [1:0] m, input logic ds, input logic gen, input logic [15:0] d);
        {mode_select_high, mode_select_low} = m;
        baud_double_select = ds;
        baud_src_gen = gen;
        {baud_divisor_high, baud_divisor_low} = d;
        step(4);
    endtask : cfg
    // ninth bit goes out with the data, never after it
    task automatic write(input logic [7:0] d, input logic n9);
        tx_data = d;
        tx_ninth_bit = n9;
        tx_valid = 1'h1;
        while (tx_ready !== 1'h1) step(1);
        step(1);
        tx_valid = 1'h0;
        step(1);
    endtask : write
    // stall two cycles so the word must hold, then pop it
    task automatic take(input logic [8:0] exp);
        while (rx_valid !== 1'h1) step(1);
        step(2);
        chk({7'h00, rx_ninth_bit, rx_data}, {7'h00, exp});
        rx_ready = 1'h1;
        step(1);
        rx_ready = 1'h0;
    endtask : take
    // ==========================================================
    // scenarios
    task automatic t_tx9();
        logic [10:0] f;
        int t0;
        for (int ds = 0; ds < 2; ds++) begin
            cfg(MODE_FIX9, ds[0], 1'h1, 16'h0000);
            write(8'ha5, ds[0]);
            i_eub_remote.grab(f, t0, 11, ds ? 16 : 32);
            chk({5'h00, f}, {5'h00, 1'h1, ds[0], 8'ha5, 1'h0});
            chk(tx_ready, 1'h0);
            while (tx_done !== 1'h1) step(1);
        end
    endtask : t_tx9
    // mode 1 on divisor 1, fixed 9-bit, variable 9-bit on halved and full timer rate
    task automatic t_rx();
        logic [1:0] md [4] = '{MODE_UART8, MODE_FIX9, MODE_VAR9, MODE_VAR9};
        int bc [4] = '{32, 16, 64, 32};
        for (int i = 0; i < 4; i++) begin
            cfg(md[i], i != 2, i == 0, 16'h0001);
            i_eub_remote.send({1'h1, i == 0, 8'h5a + i[7:0], 1'h0}, i == 0 ? 10 : 11, bc[i]);
            take({i == 0, 8'h5a + i[7:0]});
        end
    endtask : t_rx
    task automatic t_ferr();
        cfg(MODE_UART8, 1'h1, 1'h1, 16'h0000);
        rx_ready = 1'h1;
        i_eub_remote.send({2'h0, 8'h81, 1'h0}, 10, 16);
        step(40);
        chk(frame_err, 1'h1);
        chk(ctl_bit7, 1'h0);
        frame_err_view_select = 1'h1;
        step(2);
        chk(ctl_bit7, 1'h1);
        frame_err_clr = 1'h1;
        step(1);
        frame_err_clr = 1'h0;
        step(2);
        chk({frame_err, ctl_bit7}, 2'h0);
        frame_err_view_select = 1'h0;
    endtask : t_ferr
    // ten low bit times must not flag; sixteen and a half must
    task automatic t_brk();
        break_reset_en = 1'h1;
        fork
            i_eub_remote.send(11'h000, 11, 24);
            #640 chk(break_det, 1'h0);
        join
        chk({break_det, req_seen}, 2'h3);
        break_clr = 1'h1;
        frame_err_clr = 1'h1;
        step(1);
        {break_clr, frame_err_clr, break_reset_en} = 3'h0;
        step(2);
        chk(break_det, 1'h0);
        rx_ready = 1'h0;
    endtask : t_brk
    task automatic t_dbuf();
        logic [10:0] f0, f1;
        int t0, t1;
        tx_double_buffer_en = 1'h1;
        fork
            begin
                i_eub_remote.grab(f0, t0, 10, 16);
                i_eub_remote.grab(f1, t1, 10, 16);
            end
            begin
                write(8'h96, 1'h1);
                write(8'h69, 1'h1);
            end
        join
        chk({6'h00, f0[9:0]}, {6'h00, 1'h1, 8'h96, 1'h0});
        chk({6'h00, f1[9:0]}, {6'h00, 1'h1, 8'h69, 1'h0});
        chk(16'(t1 - t0), 16'h00a0);
        step(200);
        tx_double_buffer_en = 1'h0;
    endtask : t_dbuf
    // shift mode: half duplex, so receive held off; double buffer kept off
    task automatic t_shift();
        logic [7:0] d;
        time tp;
        rx_enable = 1'h0;
        cfg(MODE_SHIFT, 1'h1, 1'h1, 16'h0000);
        write(8'hc3, 1'h0);
        for (int i = 0; i < 8; i++) begin
            @(posedge txd_out);
            d[i] = rxd_out;
            if (i > 0) chk(16'($time - tp), 16'h0040);
            tp = $time;
        end
        chk({7'h00, rxd_oe, d}, 16'h01c3);
        step(1);
        rx_enable = 1'h1;
        take(9'h0ff);
    endtask : t_shift
    // ==========================================================
    // main sequence
    initial begin
        repeat (3) @(posedge clk_sys);
        #1;
        arst_n = 1'h1;
        step(2);
        rx_enable = 1'h1;
        t_tx9();
        t_rx();
        t_ferr();
        t_brk();
        t_dbuf();
        t_shift();
        step(40);
        results();
    end
endmodule : tb_top
`default_nettype wire
